// ==== hdl/bshp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module bshp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = bshp_pkg::WBUF_DEPTH_DEF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] EMPTY_CNT = '0;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("bshp_fifo: DEPTH must be a power of two, at least 2");
   end
   if (W < 1) begin : g_bad_width
      $error("bshp_fifo: W must be positive");
   end

   logic [W-1:0] store [0:DEPTH-1];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = (count != FULL_CNT);
   assign out_valid = (count != EMPTY_CNT);
   assign out_data = store[rd_ptr];

   always_ff @(posedge core_clk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

`default_nettype wire

// ==== hdl/bshp_pkg.sv ====
`default_nettype none

package bshp_pkg;

   // ****************************************
   // Data bus geometry
   // ****************************************
   localparam int LANE_W = 9;
   localparam int LANES_WIDE = 4;
   localparam int LANES_NARROW = 2;
   localparam int DQ_W = 36;
   localparam int BW_W = 4;
   localparam int ADDR_W_DEF = 18;
   localparam int ADDR_W_MAX = 20;

   // ****************************************
   // Write buffer and loop lock
   // ****************************************
   localparam int WBUF_DEPTH_DEF = 16;
   // Lock time counted in command clock periods
   localparam int LOCK_KCYC_DEF = 1024;

   // ****************************************
   // Read latency in launch-clock negative rises
   // ****************************************
   localparam logic [1:0] RD_LAT_DLL = 2'h2;
   localparam logic [1:0] RD_LAT_BYPASS = 2'h1;
   localparam logic [1:0] RD_LAT_LAST = 2'h1;
   localparam logic [1:0] RD_LAT_STEP = 2'h1;

   // ****************************************
   // Burst beats and link pin positions
   // ****************************************
   localparam logic BEAT_FIRST = 1'b0;
   localparam logic BEAT_SECOND = 1'b1;
   localparam int CK_KP = 0;
   localparam int CK_KN = 1;
   localparam int CK_CP = 2;
   localparam int CK_CN = 3;
   localparam int CK_W = 4;

   typedef enum {WR_IDLE, WR_BEAT0, WR_BEAT1} bshp_wr_e;
   typedef enum {DLL_BYPASS, DLL_LOCKING, DLL_LOCKED} bshp_dll_e;

endpackage

`default_nettype wire

// ==== hdl/bshp_port.sv ====
// Operation
// - Address and controls are taken only on command clock positive rising edges.
// - Write data taken on positive then negative command clock rising edges.
// - Read data launched by output clock pair when it is toggling.
// - With both output clocks high, read data follows command clock edges.
// - Echo clocks toggle continuously, even while data pins are released.
// - Echo clock edges change together with read data updates.
// - Loop-bypass low bypasses the loop and discards its lock.
// - Loop-bypass high starts the loop; lock after the lock time.
// - Loop bypassed gives one cycle less read latency.
// - Address pins ignored unless the cycle loads a command.
// - Data pins released whenever no read is being driven.
// - Narrow build uses 18 data lines, wide build uses 36.
// - With load low, select high marks a read, low a write.
// - Each active-low byte strobe enables its lane, sampled with its beat.
// - First read beat on a negative rise one and a half cycles on, half a cycle on with the loop bypassed.
`timescale 1ns/1ps
`default_nettype none

module bshp_port #(
   parameter int ADDR_W = bshp_pkg::ADDR_W_DEF,
   parameter bit WIDE = 1'b1,
   parameter int LOCK_KCYC = bshp_pkg::LOCK_KCYC_DEF,
   parameter int WBUF_DEPTH = bshp_pkg::WBUF_DEPTH_DEF
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Command clock pair
   input wire logic k_pos,
   input wire logic k_neg,
   // Output clock pair
   input wire logic c_pos,
   input wire logic c_neg,
   // Command pins
   input wire logic load_n,
   input wire logic rw_sel,
   input wire logic [ADDR_W-1:0] addr_pins,
   input wire logic [bshp_pkg::BW_W-1:0] byte_wr_n,
   // Data pins
   input wire logic [bshp_pkg::DQ_W-1:0] data_io_in,
   output logic [bshp_pkg::DQ_W-1:0] data_io_out,
   output logic [bshp_pkg::DQ_W-1:0] data_io_oe,
   // Loop control
   input wire logic dll_run,
   output logic dll_locked,
   // Echo clocks
   output logic echo_pos,
   output logic echo_neg,
   // Status
   output logic wr_overrun
);

   // ****************************************
   // Geometry and checks
   // ****************************************
   localparam int LANES = WIDE ? bshp_pkg::LANES_WIDE : bshp_pkg::LANES_NARROW;
   localparam int DW = LANES * bshp_pkg::LANE_W;
   localparam int DQW = bshp_pkg::DQ_W;
   localparam int BWW = bshp_pkg::BW_W;
   localparam int BUF_W = ADDR_W + 1 + BWW + DQW;
   localparam int WORDS = 2 ** (ADDR_W + 1);
   localparam int LCW = $clog2(LOCK_KCYC + 1);
   localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_KCYC - 1);
   localparam logic [DQW-1:0] DQ_MASK = DQW'(({{DQW{1'b0}}, 1'b1} << DW) - 1);

   if (ADDR_W < 1 || ADDR_W > bshp_pkg::ADDR_W_MAX) begin : g_bad_addr
      $error("bshp_port: ADDR_W out of range");
   end
   if (LOCK_KCYC < 1) begin : g_bad_lock
      $error("bshp_port: LOCK_KCYC must be at least 1");
   end

   // Lane enables from active-low byte strobes, unused lanes forced off
   function automatic logic [BWW-1:0] lane_enable(input logic [BWW-1:0] strobe_n);
      logic [BWW-1:0] en;
      en = '0;
      for (int i = 0; i < BWW; i++) begin
         en[i] = ~strobe_n[i] && (i < LANES);
      end
      return en;
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // The link clocks are sampled, not used as clocks: 160 ns link period
   // against 20 ns core period leaves several samples per phase.
   logic [bshp_pkg::CK_W-1:0] ck_s1;
   logic [bshp_pkg::CK_W-1:0] ck_s2;
   logic [bshp_pkg::CK_W-1:0] ck_prev;
   logic load_n_s1;
   logic load_n_s2;
   logic rw_s1;
   logic rw_s2;
   logic dll_s1;
   logic dll_s2;
   logic [ADDR_W-1:0] addr_s1;
   logic [ADDR_W-1:0] addr_s2;
   logic [BWW-1:0] bw_s1;
   logic [BWW-1:0] bw_s2;
   logic [DQW-1:0] din_s1;
   logic [DQW-1:0] din_s2;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ck_s1 <= '0;
         ck_s2 <= '0;
         ck_prev <= '0;
         load_n_s1 <= 1'b1;
         load_n_s2 <= 1'b1;
         rw_s1 <= 1'b0;
         rw_s2 <= 1'b0;
         dll_s1 <= 1'b0;
         dll_s2 <= 1'b0;
      end else begin
         ck_s1 <= {c_neg, c_pos, k_neg, k_pos};
         ck_s2 <= ck_s1;
         ck_prev <= ck_s2;
         load_n_s1 <= load_n;
         load_n_s2 <= load_n_s1;
         rw_s1 <= rw_sel;
         rw_s2 <= rw_s1;
         dll_s1 <= dll_run;
         dll_s2 <= dll_s1;
      end
   end

   // Wide data paths carry no reset; only their sampled value matters
   always_ff @(posedge core_clk) begin
      addr_s1 <= addr_pins;
      addr_s2 <= addr_s1;
      bw_s1 <= byte_wr_n;
      bw_s2 <= bw_s1;
      din_s1 <= data_io_in;
      din_s2 <= din_s1;
   end

   // ****************************************
   // Clock edges and launch clock choice
   // ****************************************
   wire [bshp_pkg::CK_W-1:0] ck_rise = ck_s2 & ~ck_prev;
   wire k_rise = ck_rise[bshp_pkg::CK_KP];
   wire kn_rise = ck_rise[bshp_pkg::CK_KN];
   wire c_tied = ck_s2[bshp_pkg::CK_CP] & ck_s2[bshp_pkg::CK_CN];
   wire launch_pos = c_tied ? ck_s2[bshp_pkg::CK_KP] : ck_s2[bshp_pkg::CK_CP];
   wire launch_neg = c_tied ? ck_s2[bshp_pkg::CK_KN] : ck_s2[bshp_pkg::CK_CN];
   wire pos_rise = c_tied ? k_rise : ck_rise[bshp_pkg::CK_CP];
   wire neg_rise = c_tied ? kn_rise : ck_rise[bshp_pkg::CK_CN];

   // ****************************************
   // Command decode
   // ****************************************
   wire cmd_load = k_rise & ~load_n_s2;
   wire cmd_rd = cmd_load & rw_s2;
   wire cmd_wr = cmd_load & ~rw_s2;

   // ****************************************
   // Loop control
   // ****************************************
   bshp_pkg::bshp_dll_e dll_st;
   bshp_pkg::bshp_dll_e next_dll_st;
   logic [LCW-1:0] lock_cnt;
   logic [LCW-1:0] next_lock_cnt;
   wire dll_bypassed = (dll_st == bshp_pkg::DLL_BYPASS);

   always_comb begin
      next_dll_st = dll_st;
      next_lock_cnt = lock_cnt;
      case (dll_st)
         bshp_pkg::DLL_BYPASS: begin
            next_lock_cnt = '0;
            if (dll_s2) begin
               next_dll_st = bshp_pkg::DLL_LOCKING;
            end
         end
         bshp_pkg::DLL_LOCKING: begin
            if (k_rise) begin
               if (lock_cnt == LOCK_LAST) begin
                  next_dll_st = bshp_pkg::DLL_LOCKED;
               end else begin
                  next_lock_cnt = lock_cnt + LCW'(1);
               end
            end
         end
         bshp_pkg::DLL_LOCKED: begin
            next_dll_st = bshp_pkg::DLL_LOCKED;
         end
         default: begin
            next_dll_st = bshp_pkg::DLL_BYPASS;
         end
      endcase
      if (!dll_s2) begin
         next_dll_st = bshp_pkg::DLL_BYPASS;
         next_lock_cnt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dll_st <= bshp_pkg::DLL_BYPASS;
         lock_cnt <= '0;
         dll_locked <= 1'b0;
      end else begin
         dll_st <= next_dll_st;
         lock_cnt <= next_lock_cnt;
         dll_locked <= (next_dll_st == bshp_pkg::DLL_LOCKED);
      end
   end

   // ****************************************
   // Write capture
   // ****************************************
   bshp_pkg::bshp_wr_e wr_st;
   bshp_pkg::bshp_wr_e next_wr_st;
   logic [ADDR_W-1:0] wr_addr;

   always_comb begin
      next_wr_st = wr_st;
      case (wr_st)
         bshp_pkg::WR_IDLE: begin
            if (cmd_wr) begin
               next_wr_st = bshp_pkg::WR_BEAT0;
            end
         end
         bshp_pkg::WR_BEAT0: begin
            if (k_rise) begin
               next_wr_st = bshp_pkg::WR_BEAT1;
            end
         end
         bshp_pkg::WR_BEAT1: begin
            if (kn_rise) begin
               next_wr_st = bshp_pkg::WR_IDLE;
            end
         end
         default: begin
            next_wr_st = bshp_pkg::WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_st <= bshp_pkg::WR_IDLE;
         wr_addr <= '0;
      end else begin
         wr_st <= next_wr_st;
         if (cmd_wr) begin
            wr_addr <= addr_s2;
         end
      end
   end

   // First beat one command cycle later on the positive rise, second on the
   // following negative rise; strobes travel with their own beat.
   wire beat0_take = (wr_st == bshp_pkg::WR_BEAT0) & k_rise;
   wire beat1_take = (wr_st == bshp_pkg::WR_BEAT1) & kn_rise;
   wire buf_push = beat0_take | beat1_take;
   wire push_beat = beat1_take ? bshp_pkg::BEAT_SECOND : bshp_pkg::BEAT_FIRST;
   wire [BUF_W-1:0] push_word = {wr_addr, push_beat, bw_s2, din_s2 & DQ_MASK};
   logic buf_in_ready;
   logic buf_out_valid;
   logic [BUF_W-1:0] pop_word;
   // The array port serves a read fetch first; the buffer absorbs the stall
   wire drain_ready = ~cmd_rd;
   wire buf_pop = buf_out_valid & drain_ready;

   bshp_fifo #(
      .W(BUF_W),
      .DEPTH(WBUF_DEPTH)
   ) u_wbuf (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(buf_push),
      .in_ready(buf_in_ready),
      .in_data(push_word),
      .out_valid(buf_out_valid),
      .out_ready(drain_ready),
      .out_data(pop_word)
   );

   // The pins cannot be held off, so a beat refused by a full buffer is lost
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_overrun <= 1'b0;
      end else if (buf_push && !buf_in_ready) begin
         wr_overrun <= 1'b1;
      end
   end

   // ****************************************
   // Storage array
   // ****************************************
   logic [DQW-1:0] mem [0:WORDS-1];
   wire [ADDR_W-1:0] pop_addr = pop_word[BUF_W-1 -: ADDR_W];
   wire pop_beat = pop_word[BWW + DQW];
   wire [BWW-1:0] pop_en = lane_enable(pop_word[DQW +: BWW]);
   wire [DQW-1:0] pop_data = pop_word[DQW-1:0];
   wire [ADDR_W:0] pop_idx = {pop_addr, pop_beat};
   wire [ADDR_W:0] fetch_idx0 = {addr_s2, bshp_pkg::BEAT_FIRST};
   wire [ADDR_W:0] fetch_idx1 = {addr_s2, bshp_pkg::BEAT_SECOND};

   always_ff @(posedge core_clk) begin
      if (buf_pop) begin
         for (int i = 0; i < BWW; i++) begin
            if (pop_en[i]) begin
               mem[pop_idx][i*bshp_pkg::LANE_W +: bshp_pkg::LANE_W] <=
                  pop_data[i*bshp_pkg::LANE_W +: bshp_pkg::LANE_W];
            end
         end
      end
   end

   // Buffer drains within a few core cycles, far inside the command spacing,
   // so a read two or more command cycles after a write to the same burst sees the new data.
   logic [DQW-1:0] rd_q0;
   logic [DQW-1:0] rd_q1;

   always_ff @(posedge core_clk) begin
      if (cmd_rd) begin
         rd_q0 <= mem[fetch_idx0] & DQ_MASK;
         rd_q1 <= mem[fetch_idx1] & DQ_MASK;
      end
   end

   // ****************************************
   // Read launch
   // ****************************************
   logic rd_armed;
   logic [1:0] rd_cnt;
   logic beat2_due;
   wire first_due = rd_armed & (rd_cnt == bshp_pkg::RD_LAT_LAST);
   wire [1:0] rd_lat = dll_bypassed ? bshp_pkg::RD_LAT_BYPASS
                                    : bshp_pkg::RD_LAT_DLL;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_armed <= 1'b0;
         rd_cnt <= '0;
         beat2_due <= 1'b0;
         data_io_out <= '0;
         data_io_oe <= '0;
      end else begin
         if (neg_rise) begin
            if (first_due) begin
               data_io_out <= rd_q0;
               data_io_oe <= DQ_MASK;
               rd_armed <= 1'b0;
               beat2_due <= 1'b1;
            end else begin
               if (rd_armed) begin
                  rd_cnt <= rd_cnt - bshp_pkg::RD_LAT_STEP;
               end
               if (!beat2_due) begin
                  data_io_oe <= '0;
               end
            end
         end
         if (pos_rise && beat2_due) begin
            data_io_out <= rd_q1;
            beat2_due <= 1'b0;
         end
         if (cmd_rd) begin
            rd_armed <= 1'b1;
            rd_cnt <= rd_lat;
         end
      end
   end

   // ****************************************
   // Echo clocks
   // ****************************************
   // Registered from the same samples that time the data, so both move on
   // the same core edge; never gated by the data enables.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         echo_pos <= 1'b0;
         echo_neg <= 1'b0;
      end else begin
         echo_pos <= launch_pos;
         echo_neg <= launch_neg;
      end
   end

endmodule

`default_nettype wire

// ==== testbench/bshp_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module bshp_ctrl_model #(
   parameter int ADDR_W = 18
) (
   // Output clock select
   input wire logic c_run,
   // Link clocks
   output logic k_pos,
   output logic k_neg,
   output logic c_pos,
   output logic c_neg,
   // Command and data
   output logic load_n,
   output logic rw_sel,
   output logic [ADDR_W-1:0] addr_pins,
   output logic [3:0] byte_wr_n,
   output logic [35:0] ctl_data
);
   // Quarter-phase clock: pins change midway between sampling edges
   logic kq;

   assign k_neg = ~k_pos;
   assign c_pos = c_run ? kq : 1'b1;
   assign c_neg = c_run ? ~kq : 1'b1;

   // 160 ns link period, far below the bypass ceiling
   initial begin
      k_pos = 1'b0;
      kq = 1'b0;
      load_n = 1'b1;
      rw_sel = 1'b0;
      addr_pins = '0;
      byte_wr_n = 4'hF;
      ctl_data = '0;
      #7;
      forever begin
         #40 k_pos = ~k_pos;
         #40 kq = ~kq;
      end
   end

   task automatic op(input logic rd, input logic [ADDR_W-1:0] a, input logic [35:0] d0,
                     input logic [35:0] d1, input logic [3:0] b0, input logic [3:0] b1);
      @(negedge kq);
      load_n <= 1'b0;
      rw_sel <= rd;
      addr_pins <= a;
      @(posedge kq);
      load_n <= 1'b1;
      addr_pins <= ~a;
      rw_sel <= ~rd;
      if (!rd) begin
         @(negedge kq);
         ctl_data <= d0;
         byte_wr_n <= b0;
         @(posedge kq);
         ctl_data <= d1;
         byte_wr_n <= b1;
         @(negedge kq);
         // Released bus: no stale copy of the last beat
         ctl_data <= ~d1;
         byte_wr_n <= 4'hF;
      end
   endtask
endmodule

`default_nettype wire

// ==== testbench/bshp_port_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module bshp_port_assertions #(
   parameter bit WIDE = 1'b1,
   parameter int LOCK_KCYC = bshp_pkg::LOCK_KCYC_DEF,
   parameter int LINK_CYC = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Command pins
   input wire logic load_n,
   input wire logic rw_sel,
   // Data pins
   input wire logic [bshp_pkg::DQ_W-1:0] data_io_out,
   input wire logic [bshp_pkg::DQ_W-1:0] data_io_oe,
   // Loop, echo and status
   input wire logic dll_run,
   input wire logic dll_locked,
   input wire logic echo_pos,
   input wire logic echo_neg,
   input wire logic wr_overrun
);
   localparam logic [35:0] OE_FULL = WIDE ? 36'hF_FFFF_FFFF : 36'h0_0003_FFFF;
   localparam int LOCK_MAX = (LOCK_KCYC + 1) * LINK_CYC + 8;
   logic [4:0] echo_age;
   logic [5:0] rd_age;
   logic [15:0] run_cnt;

   // ****************************************
   // Ages since echo edge, read load, loop start
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         echo_age <= 5'h0;
         rd_age <= 6'h3F;
         run_cnt <= 16'h0;
      end else begin
         echo_age <= $changed(echo_pos) ? 5'h0 : echo_age + 5'h1;
         rd_age <= (!load_n && rw_sel) ? 6'h0 : (rd_age == 6'h3F ? rd_age : rd_age + 6'h1);
         run_cnt <= !dll_run ? 16'h0 : (run_cnt == 16'hFFFF ? run_cnt : run_cnt + 16'h1);
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_reset_quiet;
      disable iff (1'b0)
      sys_rst |=> data_io_oe == '0 && !dll_locked && !echo_pos && !echo_neg && !wr_overrun;
   endproperty
   property p_echo_runs;
      echo_age < 5'hC;
   endproperty
   property p_oe_lanes;
      data_io_oe == '0 || data_io_oe == OE_FULL;
   endproperty
   property p_oe_stands;
      $rose(data_io_oe[0]) |-> data_io_oe[0] [*8];
   endproperty
   property p_oe_after_read;
      $rose(data_io_oe[0]) |-> rd_age < 6'h1C;
   endproperty
   property p_beat_with_echo;
      data_io_oe[0] && $changed(data_io_out) |-> $changed(echo_pos) || $changed(echo_neg);
   endproperty
   property p_lock_drop;
      !dll_run [*6] |-> !dll_locked;
   endproperty
   property p_lock_time;
      run_cnt == 16'(LOCK_MAX) |-> dll_locked;
   endproperty
   property p_lock_wait;
      $rose(dll_locked) |-> run_cnt > 16'((LOCK_KCYC - 1) * LINK_CYC);
   endproperty
   property p_overrun_sticky;
      wr_overrun |=> wr_overrun;
   endproperty

   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet");
   a_echo_runs: assert property (p_echo_runs) else $error("echo clock stalled");
   a_oe_lanes: assert property (p_oe_lanes) else $error("partial data lanes driven");
   a_oe_stands: assert property (p_oe_stands) else $error("read burst cut short");
   a_oe_after_read: assert property (p_oe_after_read) else $error("drive without read");
   a_beat_with_echo: assert property (p_beat_with_echo) else $error("data moved off echo");
   a_lock_drop: assert property (p_lock_drop) else $error("lock kept in bypass");
   a_lock_time: assert property (p_lock_time) else $error("lock too late");
   a_lock_wait: assert property (p_lock_wait) else $error("lock too early");
   a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun flag fell");

   c_read_byp: cover property ($rose(data_io_oe[0]) && !dll_locked);
   c_read_lock: cover property ($rose(data_io_oe[0]) && dll_locked);
   c_lock: cover property ($rose(dll_locked));
endmodule

bind bshp_port bshp_port_assertions #(
   .WIDE(WIDE),
   .LOCK_KCYC(LOCK_KCYC)
) bshp_port_assertions_inst (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .load_n(load_n),
   .rw_sel(rw_sel),
   .data_io_out(data_io_out),
   .data_io_oe(data_io_oe),
   .dll_run(dll_run),
   .dll_locked(dll_locked),
   .echo_pos(echo_pos),
   .echo_neg(echo_neg),
   .wr_overrun(wr_overrun)
);

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int AW = 18;
   localparam logic [AW-1:0] A = 18'h2_5A5C;
   localparam logic [35:0] D0 = 36'h1_2345_6789;
   localparam logic [35:0] D1 = 36'hF_EDCB_A987;
   localparam logic [35:0] N0 = 36'hA_AAAA_AAAA;
   localparam logic [35:0] N1 = 36'h5_5555_5555;
   logic core_clk, sys_rst, dll_run, c_run, k_pos, k_neg, c_pos, c_neg, load_n, rw_sel;
   logic dll_locked, echo_pos, echo_neg, wr_overrun;
   logic [AW-1:0] addr_pins;
   logic [3:0] byte_wr_n;
   logic [35:0] ctl_data, bus, data_io_out, data_io_oe, e0, e1;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int lat_b, lat_r, lat_c;

   // Wire level: device wins on lanes it drives
   assign bus = (data_io_oe & data_io_out) | (~data_io_oe & ctl_data);

   bshp_ctrl_model #(.ADDR_W(AW)) bshp_ctrl_model_inst (.c_run(c_run), .k_pos(k_pos),
      .k_neg(k_neg), .c_pos(c_pos), .c_neg(c_neg), .load_n(load_n), .rw_sel(rw_sel),
      .addr_pins(addr_pins), .byte_wr_n(byte_wr_n), .ctl_data(ctl_data));

   bshp_port #(.ADDR_W(AW), .WIDE(1'b1), .LOCK_KCYC(4), .WBUF_DEPTH(16)) bshp_port_inst (
      .core_clk(core_clk), .sys_rst(sys_rst), .k_pos(k_pos), .k_neg(k_neg), .c_pos(c_pos),
      .c_neg(c_neg), .load_n(load_n), .rw_sel(rw_sel), .addr_pins(addr_pins),
      .byte_wr_n(byte_wr_n), .data_io_in(bus), .data_io_out(data_io_out),
      .data_io_oe(data_io_oe), .dll_run(dll_run), .dll_locked(dll_locked),
      .echo_pos(echo_pos), .echo_neg(echo_neg), .wr_overrun(wr_overrun));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   function automatic logic [35:0] mrg(input logic [35:0] o, n, input logic [3:0] b);
      mrg = o;
      for (int i = 0; i < 4; i++)
         if (!b[i]) mrg[9*i +: 9] = n[9*i +: 9];
   endfunction

   task automatic wr(input logic [AW-1:0] a, input logic [35:0] d0, d1, input logic [3:0] b0, b1);
      bshp_ctrl_model_inst.op(1'b0, a, d0, d1, b0, b1);
      for (int n = 0; n < 24; n++) begin
         tick(1);
         chk("oe_wr", 36'h0, data_io_oe);
      end
   endtask

   task automatic rd(input logic [AW-1:0] a, input logic [35:0] x0, x1, output int lat);
      lat = 0;
      bshp_ctrl_model_inst.op(1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
      while (data_io_oe[0] !== 1'b1 && lat < 40) begin
         tick(1);
         lat++;
      end
      chk("oe", 36'hF_FFFF_FFFF, data_io_oe);
      chk("beat0", x0, data_io_out);
      chk("echo0", 36'h2, {34'h0, echo_neg, echo_pos});
      tick(4);
      chk("beat1", x1, data_io_out);
      chk("echo", 36'h1, {34'h0, echo_neg, echo_pos});
      tick(4);
      chk("oe_off", 36'h0, data_io_oe);
   endtask

   task automatic t_reset();
      tick(1);
      chk("oe_rst", 36'h0, data_io_oe);
      chk("lock_rst", 36'h0, {35'h0, dll_locked});
      tick(8);
      $display("test reset done");
   endtask

   task automatic t_rw();
      wr(A, D0, D1, 4'h0, 4'h0);
      rd(A, D0, D1, lat_b);
      chk("lat_byp", 36'h1, {35'h0, lat_b inside {[5:9]}});
      e0 = mrg(D0, N0, 4'h5);
      e1 = mrg(D1, N1, 4'hA);
      wr(A, N0, N1, 4'h5, 4'hA);
      rd(A, e0, e1, lat_b);
      chk("overrun", 36'h0, {35'h0, wr_overrun});
      $display("test write read done");
   endtask

   task automatic t_dll();
      int n;
      n = 0;
      @(posedge core_clk);
      dll_run <= 1'b1;
      while (dll_locked !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      chk("locked", 36'h1, {35'h0, dll_locked});
      rd(A, e0, e1, lat_r);
      chk("lat_gap", 36'h8, 36'(lat_r - lat_b));
      @(posedge core_clk);
      dll_run <= 1'b0;
      tick(8);
      chk("unlock", 36'h0, {35'h0, dll_locked});
      $display("test loop done");
   endtask

   task automatic t_cclk();
      @(posedge core_clk);
      c_run <= 1'b1;
      tick(32);
      rd(A, e0, e1, lat_c);
      chk("lat_c", 36'h2, 36'(lat_c - lat_b));
      @(posedge core_clk);
      c_run <= 1'b0;
      tick(32);
      rd(A, e0, e1, lat_c);
      chk("lat_k", 36'h0, 36'(lat_c - lat_b));
      $display("test output clocks done");
   endtask

   initial begin
      sys_rst = 1'b1;
      dll_run = 1'b0;
      c_run = 1'b0;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_rw();
      t_dll();
      t_cclk();
      end_sim();
   end
endmodule

`default_nettype wire
